// *** src/pulse_period_width_timer.sv ***
// Overview of operation
// - start flag set makes counter advance per tick, or per counted edge in event mode
// - tick from main div 1/8/32 or sub div 32
// - mode picks period fall/rise or width edges
// - first edge clears counter, no interrupt
// - later edges capture, request, clear counter
// - capture and overflow both set request bit
// - mode write while started clears overflow
// - software never sets the overflow flag
// - overflow flag reads one after reset
// - counter not cleared at start, early overflow
// - changed measure select after start sets request
// - same measure select value leaves request alone
// - start flag resets to zero; load first
// - live count read, reload moment reads FFFF
// - halted write then read returns written value in timer and event modes
// - counter, reload, timer register sixteen bits
// - measure read gives captured result
// - timer register writes ignored when measuring
//
// Decided for this implementation: the placing of the registers and strobed register access.
`timescale 1ns/100ps
`default_nettype none
module pulse_period_width_timer
  import pulse_timer_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata_r,
  // pins
  input wire logic pulse_measure_input,
  input wire logic sub_clock_pin,
  // interrupt request bit, level
  output logic irq_request_r
);
  logic start_r; // count start flag
  logic [1:0] op_r; // operating mode
  logic [1:0] sel_r; // edge select
  logic [1:0] src_r; // count source
  logic ovf_r; // overflow flag
  logic [15:0] cnt_r;
  logic [15:0] reload_r; // reload / capture register
  meas_state_t mstate_r; // measurement sequencing
  logic pin_s1_r, pin_s2_r; // pin synchroniser
  logic pin_d_r; // previous synced level, event edges
  logic smp_r; // level sampled at the last tick
  logic tick; // count source tick
  logic wr_ctrl, wr_mode, wr_timer, wr_irq;
  logic measuring; // started in measurement mode
  logic meas_edge; // effective edge on a tick
  logic capture; // edge that copies the count
  logic ev_edge; // counted edge in event mode
  logic reload_evt; // underflow reload this cycle
  logic ovf_evt; // measurement counter overflow
  logic sel_change; // select bits rewritten differently
  logic [15:0] rd_nxt;

  //////////////////////////////////////////////////////////////////
  // count source
  count_source_gen u_src (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .src_sel(src_r),
    .sub_clock_pin(sub_clock_pin),
    .tick_r(tick)
  );

  //////////////////////////////////////////////////////////////////
  // pin synchroniser; logic reads the second and third flops, never the first
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_r <= 1'b0;
      pin_s2_r <= 1'b0;
      pin_d_r <= 1'b0;
    end else begin
      pin_s1_r <= pulse_measure_input;
      pin_s2_r <= pin_s1_r;
      pin_d_r <= pin_s2_r;
    end
  end

  // tick-aligned sample keeps captures on counter steps
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      smp_r <= 1'b0;
    end else if (tick) begin
      smp_r <= pin_s2_r;
    end
  end

  //////////////////////////////////////////////////////////////////
  // decode and event terms
  assign wr_ctrl = reg_wr & (reg_addr == OFS_CTRL);
  assign wr_mode = reg_wr & (reg_addr == OFS_MODE);
  assign wr_timer = reg_wr & (reg_addr == OFS_TIMER);
  assign wr_irq = reg_wr & (reg_addr == OFS_IRQ);
  assign measuring = start_r & (op_r == OP_MEASURE);

  // effective edge by selected measurement mode
  always_comb begin
    meas_edge = 1'b0;
    ev_edge = 1'b0;
    unique case (sel_r)
      SEL_FALL: begin
        meas_edge = smp_r & ~pin_s2_r;
        ev_edge = pin_d_r & ~pin_s2_r;
      end
      SEL_RISE: begin
        meas_edge = ~smp_r & pin_s2_r;
        ev_edge = ~pin_d_r & pin_s2_r;
      end
      SEL_BOTH: begin
        meas_edge = smp_r ^ pin_s2_r;
        ev_edge = pin_d_r ^ pin_s2_r;
      end
      default: begin
        // reserved select code counts nothing
        meas_edge = 1'b0;
        ev_edge = 1'b0;
      end
    endcase
    meas_edge = meas_edge & tick & measuring;
    ev_edge = ev_edge & start_r & (op_r == OP_EVENT);
  end

  assign capture = meas_edge & (mstate_r == MS_RUN);
  // an edge in the same tick wins: the count is captured, not wrapped
  assign ovf_evt = measuring & tick & ~meas_edge & (cnt_r == CNT_ALL_ONES);
  assign reload_evt = (cnt_r == CNT_ZERO) & start_r &
                      (((op_r == OP_TIMER) & tick) | ev_edge);
  assign sel_change = wr_mode & measuring &
                      (reg_wdata[MODE_SEL_LSB +: 2] != sel_r);

  //////////////////////////////////////////////////////////////////
  // control register
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      start_r <= START_RST;
    end else if (wr_ctrl) begin
      start_r <= reg_wdata[CTRL_START_BIT];
    end
  end

  // mode register fields
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      op_r <= OP_RST;
      sel_r <= SEL_RST;
      src_r <= SRC_RST;
    end else if (wr_mode) begin
      op_r <= reg_wdata[MODE_OP_LSB +: 2];
      sel_r <= reg_wdata[MODE_SEL_LSB +: 2];
      src_r <= reg_wdata[MODE_SRC_LSB +: 2];
    end
  end

  // overflow flag: only hardware sets it, set beats the clearing write
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ovf_r <= OVF_RST;
    end else if (ovf_evt) begin
      ovf_r <= 1'b1;
    end else if (wr_mode & start_r) begin
      ovf_r <= 1'b0;
    end
  end

  // interrupt request bit; software clears by writing zero
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_request_r <= IRQ_RST;
    end else if (capture | ovf_evt | sel_change | reload_evt) begin
      irq_request_r <= 1'b1;
    end else if (wr_irq & ~reg_wdata[IRQ_REQ_BIT]) begin
      irq_request_r <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////
  // measurement sequencing
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mstate_r <= MS_IDLE;
    end else if (!measuring) begin
      mstate_r <= MS_IDLE;
    end else begin
      unique case (mstate_r)
        MS_IDLE: mstate_r <= MS_ARMED;
        MS_ARMED: begin
          if (meas_edge) begin
            mstate_r <= MS_RUN;
          end
        end
        MS_RUN: mstate_r <= MS_RUN;
      endcase
    end
  end

  // counter; never cleared at start, so its first value is stale
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= CNT_RST;
    end else if (!start_r) begin
      if (wr_timer & (op_r != OP_MEASURE)) begin
        cnt_r <= reg_wdata;
      end
    end else if (op_r == OP_MEASURE) begin
      if (meas_edge) begin
        cnt_r <= CNT_ZERO;
      end else if (tick) begin
        cnt_r <= cnt_r + 16'h0001;
      end
    end else if (reload_evt) begin
      cnt_r <= reload_r;
    end else if (((op_r == OP_TIMER) & tick) | ev_edge) begin
      cnt_r <= cnt_r - 16'h0001;
    end
  end

  // reload register; the first edge leaves it stale on purpose
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reload_r <= RELOAD_RST;
    end else if (capture) begin
      reload_r <= cnt_r;
    end else if (wr_timer & (op_r != OP_MEASURE)) begin
      reload_r <= reg_wdata;
    end
  end

  //////////////////////////////////////////////////////////////////
  // read path; answer stands one cycle after the strobe only
  always_comb begin
    rd_nxt = 16'h0000;
    unique case (reg_addr)
      OFS_CTRL: rd_nxt[CTRL_START_BIT] = start_r;
      OFS_MODE: begin
        rd_nxt[MODE_OP_LSB +: 2] = op_r;
        rd_nxt[MODE_SEL_LSB +: 2] = sel_r;
        rd_nxt[MODE_OVF_BIT] = ovf_r;
        rd_nxt[MODE_SRC_LSB +: 2] = src_r;
      end
      OFS_TIMER: begin
        if (op_r == OP_MEASURE) begin
          rd_nxt = reload_r;
        end else if (reload_evt) begin
          rd_nxt = CNT_ALL_ONES;
        end else begin
          rd_nxt = cnt_r;
        end
      end
      OFS_IRQ: rd_nxt[IRQ_REQ_BIT] = irq_request_r;
      default: rd_nxt = 16'h0000; // unmapped reads zero
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_r <= 16'h0000;
    end else if (reg_rd) begin
      reg_rdata_r <= rd_nxt;
    end else begin
      reg_rdata_r <= 16'h0000;
    end
  end

  //////////////////////////////////////////////////////////////////
  // checks beside the logic
  a_timer_downcount: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    start_r && op_r == OP_TIMER && tick && cnt_r != CNT_ZERO && !wr_timer
      |=> cnt_r == $past(cnt_r) - 16'h0001)
    else $error("timer did not count down on tick");

  a_first_edge_clear: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    mstate_r == MS_ARMED && meas_edge && !wr_ctrl && !wr_mode
      |=> cnt_r == CNT_ZERO && mstate_r == MS_RUN)
    else $error("first edge did not clear counter");

  a_capture_copy: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    capture |=> reload_r == $past(cnt_r) && cnt_r == CNT_ZERO && irq_request_r)
    else $error("capture did not copy and clear");

  a_overflow_request: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    ovf_evt |=> ovf_r && irq_request_r)
    else $error("overflow did not raise flag and request");

  a_mode_write_clear: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    wr_mode && start_r && !ovf_evt |=> !ovf_r)
    else $error("mode write did not clear overflow");

  a_ovf_only_hw: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    $rose(ovf_r) |-> $past(ovf_evt))
    else $error("overflow flag set without overflow");

  a_sel_change_req: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    sel_change ##1 !(wr_irq && !reg_wdata[IRQ_REQ_BIT]) |-> irq_request_r)
    else $error("select change did not request");

  a_reload_all_ones: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    reg_rd && reg_addr == OFS_TIMER && op_r != OP_MEASURE && reload_evt
      |=> reg_rdata_r == CNT_ALL_ONES ##1 reg_rdata_r == 16'h0000 || $past(reg_rd))
    else $error("read at reload did not give all ones");

  a_measure_no_write: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    op_r == OP_MEASURE && wr_timer && !capture && !wr_mode |=> $stable(reload_r))
    else $error("timer write took effect while measuring");

  a_edge_on_tick: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    meas_edge |-> tick && measuring)
    else $error("edge seen off a tick");
endmodule
`default_nettype wire

// *** src/pulse_timer_pkg.sv ***
package pulse_timer_pkg;
  // register offsets on the plain register port
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_MODE = 4'h1;
  localparam logic [3:0] OFS_TIMER = 4'h2;
  localparam logic [3:0] OFS_IRQ = 4'h3;
  // field positions
  localparam int CTRL_START_BIT = 0;
  localparam int MODE_OP_LSB = 0;
  localparam int MODE_SEL_LSB = 2;
  localparam int MODE_OVF_BIT = 5;
  localparam int MODE_SRC_LSB = 6;
  localparam int IRQ_REQ_BIT = 0;
  // reset values
  localparam logic START_RST = 1'b0;
  localparam logic OVF_RST = 1'b1;
  localparam logic IRQ_RST = 1'b0;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [15:0] RELOAD_RST = 16'h0000;
  localparam logic [1:0] OP_RST = 2'h0;
  localparam logic [1:0] SEL_RST = 2'h0;
  localparam logic [1:0] SRC_RST = 2'h0;
  // fixed counter values
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [15:0] CNT_ALL_ONES = 16'hFFFF;
  // operating modes
  localparam logic [1:0] OP_TIMER = 2'h0;
  localparam logic [1:0] OP_EVENT = 2'h1;
  localparam logic [1:0] OP_MEASURE = 2'h2;
  // edge selection, shared by event counting and measurement
  localparam logic [1:0] SEL_FALL = 2'h0;
  localparam logic [1:0] SEL_RISE = 2'h1;
  localparam logic [1:0] SEL_BOTH = 2'h2;
  // count source selection
  localparam logic [1:0] SRC_MAIN_DIV1 = 2'h0;
  localparam logic [1:0] SRC_MAIN_DIV8 = 2'h1;
  localparam logic [1:0] SRC_MAIN_DIV32 = 2'h2;
  localparam logic [1:0] SRC_SUB_DIV32 = 2'h3;
  // divider terminal counts
  localparam logic [2:0] DIV8_LAST = 3'h7;
  localparam logic [4:0] DIV32_LAST = 5'h1F;
  // measurement sequencing
  typedef enum logic [2:0] {
    MS_IDLE = 3'b001,
    MS_ARMED = 3'b010,
    MS_RUN = 3'b100
  } meas_state_t;
endpackage

// *** src/count_source_gen.sv ***
`timescale 1ns/100ps
`default_nettype none
module count_source_gen
  import pulse_timer_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // selection and secondary clock pin
  input wire logic [1:0] src_sel,
  input wire logic sub_clock_pin,
  // one-cycle count tick
  output logic tick_r
);
  logic [4:0] main_div_r; // free-running main clock divider
  logic [4:0] sub_div_r; // counts secondary clock rising edges
  logic sub_s1_r, sub_s2_r, sub_s3_r; // synchroniser plus edge stage
  logic sub_edge; // rising edge of synced secondary clock
  logic tick_nxt;

  //////////////////////////////////////////////////////////////////
  // secondary clock is a foreign level: two flops before any logic
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sub_s1_r <= 1'b0;
      sub_s2_r <= 1'b0;
      sub_s3_r <= 1'b0;
    end else begin
      sub_s1_r <= sub_clock_pin;
      sub_s2_r <= sub_s1_r;
      sub_s3_r <= sub_s2_r;
    end
  end

  assign sub_edge = sub_s2_r & ~sub_s3_r;

  // dividers run always so a source switch needs no restart
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      main_div_r <= 5'h00;
      sub_div_r <= 5'h00;
    end else begin
      main_div_r <= main_div_r + 5'h01;
      if (sub_edge) begin
        sub_div_r <= sub_div_r + 5'h01;
      end
    end
  end

  // pick the tick; the secondary clock must be well below half sys_clk
  always_comb begin
    unique case (src_sel)
      SRC_MAIN_DIV1: tick_nxt = 1'b1;
      SRC_MAIN_DIV8: tick_nxt = (main_div_r[2:0] == DIV8_LAST);
      SRC_MAIN_DIV32: tick_nxt = (main_div_r == DIV32_LAST);
      SRC_SUB_DIV32: tick_nxt = sub_edge & (sub_div_r == DIV32_LAST);
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_r <= 1'b0;
    end else begin
      tick_r <= tick_nxt;
    end
  end
endmodule
`default_nettype wire

// *** verification/pulse_source_model.sv ***
`timescale 1ns/100ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// far side: a square-wave source on the measurement pin
module pulse_source_model (
  // clock
  input wire logic sys_clk,
  // pulse shape, lengths in clock cycles
  input wire logic run,
  input wire logic [11:0] lo_len,
  input wire logic [11:0] hi_len,
  // measurement pin
  output logic pin
);
  logic [11:0] cnt_r; // cycles spent in the current level
  // idle high; a run always opens with a full high phase, so the
  // first falling edge lands exactly hi_len cycles after run rises
  always_ff @(posedge sys_clk) begin
    if (!run) begin
      pin <= 1'b1;
      cnt_r <= 12'h001;
    end else if (cnt_r == (pin ? hi_len : lo_len)) begin
      pin <= ~pin; // level flips, spacing stays exact
      cnt_r <= 12'h001;
    end else begin
      cnt_r <= cnt_r + 12'h001;
    end
  end
endmodule
`default_nettype wire

// *** verification/pulse_period_width_timer_tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// register-level bench for the pulse period and width timer
module pulse_period_width_timer_tb_top import pulse_timer_pkg::*;;
  logic sys_clk, rst_n, reg_wr, reg_rd, sub_clk, run, irq, pin; // bench drives
  logic [3:0] reg_addr; // register index
  logic [15:0] reg_wdata, reg_rdata_r, a, b; // bus data and read results
  logic [11:0] lo_len, hi_len; // pulse shape for the source model
  int n_mismatch, checked; // verdict counters

  pulse_period_width_timer i_dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r),
    .pulse_measure_input(pin), .sub_clock_pin(sub_clk), .irq_request_r(irq));
  pulse_source_model i_src (
    .sys_clk(sys_clk), .run(run), .lo_len(lo_len), .hi_len(hi_len), .pin(pin));

  ////////////////////////////////////////////////////////////////////////////////
  // clocks: 125 MHz main, secondary well under a quarter of it
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  initial begin
    sub_clk = 1'b0;
    forever #40 sub_clk = ~sub_clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // bus tasks; strobes rise after one edge and drop after the next
  task automatic wr(input logic [3:0] ad, input logic [15:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= ad;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  // read data only stands in the cycle after the strobe edge
  task automatic rd(input logic [3:0] ad, output logic [15:0] d);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= ad;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata_r;
  endtask
  // value compare
  task automatic chk16(input string nm, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // flag compare
  task automatic chk1(input string nm, input logic e, input logic g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic rchk(input logic [3:0] ad, input logic [15:0] e, input string nm);
    logic [15:0] d;
    rd(ad, d);
    chk16(nm, e, d);
  endtask
  // bounded wait for the request line, a timeout shows as a mismatch
  task automatic wait_irq(input int lim);
    int i;
    i = 0;
    #1; // a clear made at this very edge must land before the flag is looked at
    while (irq !== 1'b1 && i < lim) begin
      @(posedge sys_clk);
      #1 i++;
    end
    chk1("irq_request_r", 1'b1, irq);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // one measurement run: two captures after the arming edge
  task automatic meas(input logic [1:0] sel, input logic [1:0] src, input logic [11:0] lo,
                      input logic [11:0] hi, input logic [15:0] e1, input logic [15:0] e2);
    int tf, lim;
    tf = (sel == SEL_RISE) ? int'(hi) + int'(lo) : int'(hi); // first effective edge
    lim = 2 * (int'(lo) + int'(hi)) + 400;
    wr(OFS_CTRL, 16'h0000);
    wr(OFS_MODE, {8'h00, src, 2'b00, sel, OP_MEASURE});
    wr(OFS_CTRL, 16'h0001);
    wr(OFS_IRQ, 16'h0000);
    @(posedge sys_clk);
    lo_len <= lo;
    hi_len <= hi;
    run <= 1'b1;
    repeat (tf + 8) @(posedge sys_clk);
    #1 chk1("irq_request_r", 1'b0, irq);
    wait_irq(lim);
    wr(OFS_TIMER, 16'h5555);
    // a clear overflow flag names the capture as the cause of the request
    rchk(OFS_MODE, {8'h00, src, 2'b00, sel, OP_MEASURE}, "capture_cause");
    rchk(OFS_TIMER, e1, "capture_first");
    wr(OFS_IRQ, 16'h0000);
    wait_irq(lim);
    rchk(OFS_TIMER, e2, "capture_second");
    @(posedge sys_clk);
    run <= 1'b0;
    repeat (700) @(posedge sys_clk); // let slow sources see the idle level
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // verdict, reached from the sequence or the watchdog
  task automatic report_and_stop;
    $display("mismatches %0d comparisons %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // watchdog: whole sequence needs about 15000 cycles
  initial begin
    repeat (40000) @(posedge sys_clk);
    n_mismatch++;
    report_and_stop();
  end

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    rst_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    run = 1'b0;
    lo_len = 12'h001;
    hi_len = 12'h001;
    n_mismatch = 0;
    checked = 0;
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    // reset state and an unmapped index
    rchk(OFS_CTRL, 16'h0000, "ctrl_reset");
    rchk(OFS_MODE, 16'h0020, "mode_reset");
    rchk(OFS_TIMER, 16'h0000, "timer_reset");
    rchk(OFS_IRQ, 16'h0000, "irq_reset");
    wr(4'hF, 16'hFFFF);
    rchk(4'hF, 16'h0000, "unmapped");
    // halted load reads back whole
    wr(OFS_TIMER, 16'hA5C3);
    rchk(OFS_TIMER, 16'hA5C3, "halted_load");
    // live count while running, reads two cycles apart
    wr(OFS_TIMER, 16'h0100);
    wr(OFS_CTRL, 16'h0001);
    rd(OFS_TIMER, a);
    rd(OFS_TIMER, b);
    chk16("live_count", a - 16'h0002, b);
    // a read whose strobe meets the first reload cycle gives all ones
    wr(OFS_CTRL, 16'h0000);
    wr(OFS_TIMER, 16'h0003);
    wr(OFS_CTRL, 16'h0001);
    repeat (2) @(posedge sys_clk); // count 3, 2, 1, 0, then the reload tick
    rchk(OFS_TIMER, 16'hFFFF, "reload_read");
    // mode writes while started
    wr(OFS_CTRL, 16'h0000);
    wr(OFS_MODE, 16'h0002);
    wr(OFS_CTRL, 16'h0001);
    wr(OFS_MODE, 16'h0022);
    rchk(OFS_MODE, 16'h0002, "ovf_cleared");
    wr(OFS_IRQ, 16'h0000);
    wr(OFS_MODE, 16'h0002);
    repeat (3) @(posedge sys_clk);
    #1 chk1("irq_request_r", 1'b0, irq);
    wr(OFS_MODE, 16'h0006);
    repeat (3) @(posedge sys_clk);
    #1 chk1("irq_request_r", 1'b1, irq);
    // every edge mode, then every count source
    meas(SEL_FALL, SRC_MAIN_DIV1, 12'd20, 12'd20, 16'h0027, 16'h0027);
    meas(SEL_RISE, SRC_MAIN_DIV1, 12'd20, 12'd20, 16'h0027, 16'h0027);
    meas(SEL_BOTH, SRC_MAIN_DIV1, 12'd10, 12'd30, 16'h0009, 16'h001D);
    meas(SEL_FALL, SRC_MAIN_DIV8, 12'd40, 12'd40, 16'h0009, 16'h0009);
    meas(SEL_FALL, SRC_MAIN_DIV32, 12'd160, 12'd160, 16'h0009, 16'h0009);
    meas(SEL_FALL, SRC_SUB_DIV32, 12'd1600, 12'd1600, 16'h0009, 16'h0009);
    // event counting: a preset of two reloads on the third falling edge
    wr(OFS_CTRL, 16'h0000);
    wr(OFS_MODE, {12'h000, SEL_FALL, OP_EVENT});
    wr(OFS_TIMER, 16'h0002);
    wr(OFS_CTRL, 16'h0001);
    wr(OFS_IRQ, 16'h0000);
    @(posedge sys_clk);
    lo_len <= 12'd10;
    hi_len <= 12'd10;
    run <= 1'b1;
    repeat (40) @(posedge sys_clk);
    #1 chk1("irq_request_r", 1'b0, irq);
    wait_irq(40);
    rchk(OFS_TIMER, 16'h0002, "event_reload");
    @(posedge sys_clk);
    run <= 1'b0;
    // overflow before any edge, from a counter preset near the top
    wr(OFS_CTRL, 16'h0000);
    wr(OFS_MODE, 16'h0000);
    wr(OFS_TIMER, 16'hFFE0);
    wr(OFS_MODE, 16'h0002);
    wr(OFS_CTRL, 16'h0001);
    wr(OFS_MODE, 16'h0002);
    wr(OFS_IRQ, 16'h0000);
    wait_irq(60);
    rchk(OFS_MODE, 16'h0022, "ovf_set");
    report_and_stop();
  end
endmodule
`default_nettype wire
